// *** shared_pin_io_pkg.sv ***
package shared_pin_io_pkg;
  localparam int          PORT_W    = 16;
  localparam int          CN_W      = 24;
  localparam int          CN_A_W    = 16;
  localparam int          CN_B_W    = CN_W - CN_A_W;
  localparam int          ADDR_W    = 4;
  // Register word indices
  localparam logic [3:0]  OFS_DIR   = 4'h0;
  localparam logic [3:0]  OFS_LAT   = 4'h1;
  localparam logic [3:0]  OFS_PIN   = 4'h2;
  localparam logic [3:0]  OFS_ODC   = 4'h3;
  localparam logic [3:0]  OFS_ACFG1 = 4'h4;
  localparam logic [3:0]  OFS_ACFG2 = 4'h5;
  localparam logic [3:0]  OFS_CNEN_A = 4'h6;
  localparam logic [3:0]  OFS_CNEN_B = 4'h7;
  localparam logic [3:0]  OFS_CNPU_A = 4'h8;
  localparam logic [3:0]  OFS_CNPU_B = 4'h9;
  localparam logic [3:0]  OFS_CNSTAT = 4'ha;
  // Reset values and fields
  localparam logic [15:0] DIR_RST   = 16'hffff;
  localparam logic [15:0] ACFG_RST  = 16'h0000;
  localparam logic [15:0] ZERO16    = 16'h0000;
  localparam int          FLAG_BIT  = 0;
endpackage

// *** shared_pin_io_port.sv ***
`timescale 1ns/1ps
`default_nettype none
module shared_pin_io_port #(
  parameter logic [15:0] IMPL_MASK   = 16'hffff,
  parameter logic [15:0] OD_MASK     = 16'hffff,
  parameter logic [15:0] ANALOG_MASK = 16'h00ff,
  parameter logic [23:0] CN_MASK     = 24'hff_ffff
) (
  input  wire logic                                   sys_clk,
  input  wire logic                                   arst_n,
  input  wire logic [shared_pin_io_pkg::ADDR_W-1:0]   reg_addr,
  input  wire logic [shared_pin_io_pkg::PORT_W-1:0]   reg_wdata,
  input  wire logic                                   reg_wr,
  input  wire logic                                   reg_rd,
  output logic      [shared_pin_io_pkg::PORT_W-1:0]   reg_rdata,
  input  wire logic [shared_pin_io_pkg::PORT_W-1:0]   pin_in,
  output logic      [shared_pin_io_pkg::PORT_W-1:0]   pin_out,
  output logic      [shared_pin_io_pkg::PORT_W-1:0]   pin_oe_n,
  input  wire logic [shared_pin_io_pkg::PORT_W-1:0]   periph_enable,
  input  wire logic [shared_pin_io_pkg::PORT_W-1:0]   periph_drive,
  input  wire logic [shared_pin_io_pkg::PORT_W-1:0]   periph_out,
  output logic      [shared_pin_io_pkg::PORT_W-1:0]   periph_in,
  output logic      [shared_pin_io_pkg::PORT_W-1:0]   analog_sel,
  input  wire logic [shared_pin_io_pkg::CN_W-1:0]     change_notice,
  output logic      [shared_pin_io_pkg::CN_W-1:0]     weak_pullup_en,
  output logic                                        change_irq,
  output logic                                        change_wake
);
  import shared_pin_io_pkg::*;

  typedef struct packed {
    logic [PORT_W-1:0] dir;
    logic [PORT_W-1:0] lat;
    logic [PORT_W-1:0] odc;
    logic [PORT_W-1:0] acfg1;
    logic [PORT_W-1:0] acfg2;
    logic [CN_W-1:0]   cnen;
    logic [CN_W-1:0]   cnpu;
    logic              flag;
    logic [PORT_W-1:0] pin_s1;
    logic [PORT_W-1:0] pin_s2;
    logic [CN_W-1:0]   cn_s1;
    logic [CN_W-1:0]   cn_s2;
    logic [CN_W-1:0]   cn_prev;
    logic [PORT_W-1:0] rdata;
  } state_s;

  localparam state_s STATE_RST = '{dir: DIR_RST, acfg1: ACFG_RST, acfg2: ACFG_RST,
                                   default: '0};

  state_s            state_r;
  state_s            state_nxt;
  logic [PORT_W-1:0] own_periph;
  logic [PORT_W-1:0] port_drive;
  logic [PORT_W-1:0] analog_pin;
  logic [PORT_W-1:0] pin_read;
  logic [CN_W-1:0]   cn_event;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction

  // Output ownership and pin drive per bit
  generate
    for (genvar i = 0; i < PORT_W; i++) begin : g_pin
      always_comb begin
        own_periph[i] = periph_enable[i] & periph_drive[i];
        if (!IMPL_MASK[i]) begin
          port_drive[i] = 1'b0;
          pin_out[i]    = 1'b0;
        end else if (own_periph[i]) begin
          port_drive[i] = 1'b0;
          pin_out[i]    = periph_out[i];
        end else if (state_r.dir[i]) begin
          port_drive[i] = 1'b0;
          pin_out[i]    = 1'b0;
        end else if (state_r.odc[i]) begin
          port_drive[i] = ~state_r.lat[i];
          pin_out[i]    = 1'b0;
        end else begin
          port_drive[i] = 1'b1;
          pin_out[i]    = state_r.lat[i];
        end
        pin_oe_n[i]  = ~(IMPL_MASK[i] & (own_periph[i] | port_drive[i]));
        periph_in[i] = state_r.pin_s2[i] & ~port_drive[i];
      end
    end
  endgenerate

  assign analog_pin     = ANALOG_MASK & IMPL_MASK & ~(state_r.acfg1 & state_r.acfg2);
  assign analog_sel     = analog_pin;
  assign pin_read       = state_r.pin_s2 & ~analog_pin & IMPL_MASK;
  assign cn_event       = state_r.cnen & CN_MASK & (state_r.cn_s2 ^ state_r.cn_prev);
  assign weak_pullup_en = state_r.cnpu & CN_MASK;
  assign change_irq     = state_r.flag;
  // Unclocked wake path: holds while clocks are stopped in Sleep
  assign change_wake    = |(state_r.cnen & CN_MASK & (change_notice ^ state_r.cn_prev));
  assign reg_rdata      = state_r.rdata;

  always_comb begin
    state_nxt        = state_r;
    state_nxt.pin_s1 = pin_in;
    state_nxt.pin_s2 = state_r.pin_s1;
    state_nxt.cn_s1  = change_notice;
    state_nxt.cn_s2  = state_r.cn_s1;
    state_nxt.cn_prev = state_r.cn_s2;
    // Register writes
    if (reg_wr) begin
      if (hit(reg_addr, OFS_DIR)) begin
        state_nxt.dir = reg_wdata & IMPL_MASK;
      end else if (hit(reg_addr, OFS_LAT) || hit(reg_addr, OFS_PIN)) begin
        state_nxt.lat = reg_wdata & IMPL_MASK;
      end else if (hit(reg_addr, OFS_ODC)) begin
        state_nxt.odc = reg_wdata & OD_MASK & IMPL_MASK;
      end else if (hit(reg_addr, OFS_ACFG1)) begin
        state_nxt.acfg1 = reg_wdata;
      end else if (hit(reg_addr, OFS_ACFG2)) begin
        state_nxt.acfg2 = reg_wdata;
      end else if (hit(reg_addr, OFS_CNEN_A)) begin
        state_nxt.cnen[CN_A_W-1:0] = reg_wdata & CN_MASK[CN_A_W-1:0];
      end else if (hit(reg_addr, OFS_CNEN_B)) begin
        state_nxt.cnen[CN_W-1:CN_A_W] = reg_wdata[CN_B_W-1:0] & CN_MASK[CN_W-1:CN_A_W];
      end else if (hit(reg_addr, OFS_CNPU_A)) begin
        state_nxt.cnpu[CN_A_W-1:0] = reg_wdata & CN_MASK[CN_A_W-1:0];
      end else if (hit(reg_addr, OFS_CNPU_B)) begin
        state_nxt.cnpu[CN_W-1:CN_A_W] = reg_wdata[CN_B_W-1:0] & CN_MASK[CN_W-1:CN_A_W];
      end else if (hit(reg_addr, OFS_CNSTAT) && reg_wdata[FLAG_BIT]) begin
        state_nxt.flag = 1'b0;
      end
    end
    // A new change beats a clear in the same cycle
    if (|cn_event) begin
      state_nxt.flag = 1'b1;
    end
    // Read data, one cycle after the strobe
    state_nxt.rdata = ZERO16;
    if (reg_rd) begin
      if (hit(reg_addr, OFS_DIR)) begin
        state_nxt.rdata = state_r.dir & IMPL_MASK;
      end else if (hit(reg_addr, OFS_LAT)) begin
        state_nxt.rdata = state_r.lat & IMPL_MASK;
      end else if (hit(reg_addr, OFS_PIN)) begin
        state_nxt.rdata = pin_read;
      end else if (hit(reg_addr, OFS_ODC)) begin
        state_nxt.rdata = state_r.odc;
      end else if (hit(reg_addr, OFS_ACFG1)) begin
        state_nxt.rdata = state_r.acfg1;
      end else if (hit(reg_addr, OFS_ACFG2)) begin
        state_nxt.rdata = state_r.acfg2;
      end else if (hit(reg_addr, OFS_CNEN_A)) begin
        state_nxt.rdata = state_r.cnen[CN_A_W-1:0];
      end else if (hit(reg_addr, OFS_CNEN_B)) begin
        state_nxt.rdata = {{(PORT_W-CN_B_W){1'b0}}, state_r.cnen[CN_W-1:CN_A_W]};
      end else if (hit(reg_addr, OFS_CNPU_A)) begin
        state_nxt.rdata = state_r.cnpu[CN_A_W-1:0];
      end else if (hit(reg_addr, OFS_CNPU_B)) begin
        state_nxt.rdata = {{(PORT_W-CN_B_W){1'b0}}, state_r.cnpu[CN_W-1:CN_A_W]};
      end else if (hit(reg_addr, OFS_CNSTAT)) begin
        state_nxt.rdata = {{(PORT_W-1){1'b0}}, state_r.flag};
      end else begin
        state_nxt.rdata = ZERO16;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= STATE_RST;
    end else begin
      state_r <= state_nxt;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  a_periph_owns_pin: assert property (
    ((own_periph & IMPL_MASK) & ~pin_oe_n) == ((own_periph & IMPL_MASK))
    && ((own_periph & IMPL_MASK) & (pin_out ^ periph_out)) == ZERO16)
    else $error("peripheral does not own its pin");

  a_port_drives_idle: assert property (
    (~own_periph & ~state_r.dir & ~state_r.odc & IMPL_MASK & (pin_oe_n | (pin_out ^ state_r.lat)))
    == ZERO16)
    else $error("port fails to drive latch");

  a_loop_blocked: assert property ((periph_in & port_drive) == ZERO16)
    else $error("port output looped to peripheral");

  a_input_no_drive: assert property (
    (state_r.dir & ~own_periph & ~pin_oe_n) == ZERO16)
    else $error("input pin is driven");

  a_unimpl_read_zero: assert property (
    reg_rd && (hit(reg_addr, OFS_DIR) || hit(reg_addr, OFS_LAT) || hit(reg_addr, OFS_PIN))
    |=> (reg_rdata & ~IMPL_MASK) == ZERO16)
    else $error("unimplemented bit reads nonzero");

  a_latch_readback: assert property (
    reg_rd && hit(reg_addr, OFS_LAT) |=> reg_rdata == $past(state_r.lat))
    else $error("latch read wrong");

  a_pin_write_latch: assert property (
    reg_wr && hit(reg_addr, OFS_PIN) |=> state_r.lat == ($past(reg_wdata) & IMPL_MASK))
    else $error("pin write missed latch");

  a_open_drain_low: assert property (
    (state_r.odc & ~own_periph & ~pin_oe_n & pin_out) == ZERO16)
    else $error("open-drain pin driven high");

  a_analog_either: assert property (
    (ANALOG_MASK & IMPL_MASK & ~state_r.acfg2 & ~analog_sel) == ZERO16)
    else $error("analog select ignores second converter");

  a_analog_read_zero: assert property (
    reg_rd && hit(reg_addr, OFS_PIN) |=> (reg_rdata & $past(analog_sel)) == ZERO16)
    else $error("analog pin reads nonzero");

  a_change_sets_flag: assert property (
    |(state_r.cnen & CN_MASK & (state_r.cn_s2 ^ state_r.cn_prev)) |=> change_irq
    ##1 (change_irq || $past(reg_wr && hit(reg_addr, OFS_CNSTAT) && reg_wdata[FLAG_BIT])))
    else $error("enabled change lost");

  a_flag_clears: assert property (
    reg_wr && hit(reg_addr, OFS_CNSTAT) && reg_wdata[FLAG_BIT] && !(|cn_event)
    |=> !change_irq)
    else $error("flag clear failed");

  a_idle_periph_release: assert property (
    (periph_enable & ~periph_drive & IMPL_MASK & ~state_r.dir & ~state_r.odc & (pin_oe_n | (pin_out ^ state_r.lat))) == ZERO16)
    else $error("idle peripheral blocks port");

  a_unimpl_no_drive: assert property (
    (~IMPL_MASK & (~pin_oe_n | pin_out)) == ZERO16)
    else $error("unimplemented pin driven");

  a_unimpl_latch_zero: assert property (
    (state_r.lat & ~IMPL_MASK) == ZERO16)
    else $error("unimplemented latch bit set");

  a_dir_write: assert property (
    reg_wr && hit(reg_addr, OFS_DIR) |=> state_r.dir == ($past(reg_wdata) & IMPL_MASK))
    else $error("direction write lost");

  a_lat_write: assert property (
    reg_wr && hit(reg_addr, OFS_LAT) |=> state_r.lat == ($past(reg_wdata) & IMPL_MASK))
    else $error("latch write lost");

  a_lat_write_only: assert property (
    reg_wr && hit(reg_addr, OFS_LAT) |=> state_r.dir == $past(state_r.dir))
    else $error("latch write touched direction");

  a_pin_write_only: assert property (
    reg_wr && hit(reg_addr, OFS_PIN) |=> state_r.dir == $past(state_r.dir))
    else $error("pin write touched direction");

  a_pin_read_levels: assert property (
    reg_rd && hit(reg_addr, OFS_PIN) |=> (reg_rdata & ~$past(state_r.pin_s2)) == ZERO16)
    else $error("pin read shows level not present");

  a_odc_write: assert property (
    reg_wr && hit(reg_addr, OFS_ODC) |=> state_r.odc == ($past(reg_wdata) & OD_MASK & IMPL_MASK))
    else $error("open-drain write lost");

  a_open_drain_pull: assert property (
    (state_r.odc & ~own_periph & ~state_r.dir & IMPL_MASK & ~state_r.lat & (pin_oe_n | pin_out)) == ZERO16)
    else $error("open-drain pin not pulled low");

  a_analog_cleared: assert property (
    (ANALOG_MASK & IMPL_MASK & ~state_r.acfg1 & ~analog_sel) == ZERO16)
    else $error("cleared bit not analog");

  a_digital_only_pin: assert property (
    (analog_sel & ~ANALOG_MASK) == ZERO16)
    else $error("digital-only pin made analog");

  a_analog_both_set: assert property (
    (analog_sel & state_r.acfg1 & state_r.acfg2) == ZERO16)
    else $error("pin analog with both bits set");

  a_cnen_a_write: assert property (
    reg_wr && hit(reg_addr, OFS_CNEN_A) |=> state_r.cnen[CN_A_W-1:0] == ($past(reg_wdata) & CN_MASK[CN_A_W-1:0]))
    else $error("change enable A write lost");

  a_cnen_b_write: assert property (
    reg_wr && hit(reg_addr, OFS_CNEN_B) |=> state_r.cnen[CN_W-1:CN_A_W] == ($past(reg_wdata[CN_B_W-1:0]) & CN_MASK[CN_W-1:CN_A_W]))
    else $error("change enable B write lost");

  a_cnpu_a_write: assert property (
    reg_wr && hit(reg_addr, OFS_CNPU_A) |=> state_r.cnpu[CN_A_W-1:0] == ($past(reg_wdata) & CN_MASK[CN_A_W-1:0]))
    else $error("pull-up A write lost");

  a_cnpu_b_write: assert property (
    reg_wr && hit(reg_addr, OFS_CNPU_B) |=> state_r.cnpu[CN_W-1:CN_A_W] == ($past(reg_wdata[CN_B_W-1:0]) & CN_MASK[CN_W-1:CN_A_W]))
    else $error("pull-up B write lost");

  a_pullup_masked: assert property (
    (weak_pullup_en & ~CN_MASK) == '0)
    else $error("pull-up on missing input");

  a_flag_holds: assert property (
    change_irq && !(reg_wr && hit(reg_addr, OFS_CNSTAT) && reg_wdata[FLAG_BIT]) |=> change_irq)
    else $error("flag dropped without clear");

  a_flag_no_event: assert property (
    !change_irq && !(|cn_event) |=> !change_irq)
    else $error("flag set without enabled change");

  a_periph_in_level: assert property (
    (periph_in & ~state_r.pin_s2) == ZERO16)
    else $error("peripheral input not from pin");

  a_pin_sync_chain: assert property (
    state_r.pin_s2 == $past(state_r.pin_s1))
    else $error("pin synchroniser skipped a stage");

  a_cn_prev_track: assert property (
    state_r.cn_prev == $past(state_r.cn_s2))
    else $error("captured change level stale");

endmodule
`default_nettype wire

// *** pad_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module pad_model (
  input  wire logic [15:0] pin_out,
  input  wire logic [15:0] pin_oe_n,
  input  wire logic [15:0] ext_lvl,
  output logic      [15:0] pin_in
);
  // Driven pads show the driver, released pads the outside level
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      pin_in[i] = pin_oe_n[i] ? ext_lvl[i] : pin_out[i];
    end
  end
endmodule
`default_nettype wire

// *** tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin \
  comparisons++; \
  if ((a) !== (b)) begin \
    bad_count++; \
    $display("MISMATCH %0t got %h exp %h", $time, (a), (b)); \
  end \
end
module tb_top;
  import shared_pin_io_pkg::*;
  logic        sys_clk       = 1'b0;
  logic        arst_n        = 1'b0;
  logic [3:0]  reg_addr      = 4'h0;
  logic [15:0] reg_wdata     = 16'h0000;
  logic        reg_wr        = 1'b0;
  logic        reg_rd        = 1'b0;
  logic [15:0] ext_lvl       = 16'h0000;
  logic [15:0] periph_enable = 16'h0000;
  logic [15:0] periph_drive  = 16'h0000;
  logic [15:0] periph_out    = 16'h0000;
  logic [23:0] change_notice = 24'h00_0000;
  logic [15:0] reg_rdata, pin_in, pin_out, pin_oe_n, periph_in, analog_sel;
  logic [23:0] weak_pullup_en;
  logic        change_irq, change_wake;
  int          bad_count     = 0;
  int          comparisons   = 0;
  always #2 sys_clk = ~sys_clk;
  shared_pin_io_port #(.IMPL_MASK(16'h7fff)) dut (.sys_clk, .arst_n, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .pin_in, .pin_out, .pin_oe_n,
    .periph_enable, .periph_drive, .periph_out, .periph_in, .analog_sel,
    .change_notice, .weak_pullup_en, .change_irq, .change_wake);
  pad_model pad (.pin_out, .pin_oe_n, .ext_lvl, .pin_in);
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask
  task automatic rc(input logic [3:0] a, input logic [15:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    #1;
    `CHK(reg_rdata, e)
  endtask
  task automatic cn_hit(input int i, input logic e);
    @(posedge sys_clk);
    change_notice[i] <= ~change_notice[i];
    repeat (3) @(posedge sys_clk);
    #1;
    `CHK(change_irq, e)
    rc(OFS_CNSTAT, {15'h0000, e});
    wr(OFS_CNSTAT, 16'h0001);
    #1;
    `CHK(change_irq, 1'b0)
  endtask
  task automatic give_verdict;
    $display("Comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    #100000;
    bad_count++;
    give_verdict();
  end
  initial begin
    repeat (8) @(posedge sys_clk);
    `CHK(pin_oe_n, 16'hffff)
    `CHK(analog_sel, 16'h00ff)
    arst_n <= 1'b1;
    rc(OFS_DIR, DIR_RST & 16'h7fff);
    wr(OFS_PIN, 16'ha5a5);
    rc(OFS_LAT, 16'h25a5);
    wr(OFS_DIR, ZERO16);
    #1;
    `CHK(pin_oe_n[14:0], 15'h0000)
    `CHK(pin_out[14:0], 15'h25a5)
    rc(OFS_DIR, ZERO16);
    wr(OFS_ACFG1, 16'hffff);
    wr(OFS_ACFG2, 16'hfff0);
    wr(OFS_DIR, 16'h000f);
    wr(OFS_ODC, 16'h0030);
    #1;
    `CHK(analog_sel, 16'h000f)
    `CHK(pin_oe_n[5:4], 2'b10)
    `CHK(pin_out[4], 1'b0)
    `CHK(pin_oe_n[3:0], 4'hf)
    periph_enable <= 16'h0040;
    periph_drive  <= 16'h0040;
    periph_out    <= 16'h0040;
    repeat (3) @(posedge sys_clk);
    #1;
    `CHK(pin_out[6], 1'b1)
    `CHK(periph_in[7], 1'b0)
    rc(OFS_PIN, 16'h25c0);
    periph_drive <= 16'h0000;
    @(posedge sys_clk);
    #1;
    `CHK({pin_oe_n[6], pin_out[6]}, 2'b00)
    wr(OFS_CNEN_A, 16'h0001);
    wr(OFS_CNEN_B, 16'h0001);
    wr(OFS_CNPU_B, 16'h0080);
    #1;
    `CHK(weak_pullup_en, 24'h80_0000)
    cn_hit(0, 1'b1);
    cn_hit(1, 1'b0);
    cn_hit(16, 1'b1);
    rc(4'hf, ZERO16);
    give_verdict();
  end
endmodule
`default_nettype wire
